// ---- rcf_params.svh ----
// Constants of the reset-cause and fault flag block.
// Assumes byte-wide registers, each in one word of a 32-bit bus.
// Operation
// R01: Watchdog overflow or key violation sets bit 0; the code sets it on overflow only while wdt_mode_i is high
// R02: Power-up or pin reset clears watchdog flag
// R03: Oscillator fault sets bit 1; clear sets it
// R04: Pin reset sets bit 3; power-up clears it
// R05: Supply power-up sets bit 2
// R06: Pin NMI sets bit 4; clear zeroes it
// R07: Flags at 02h, bits 7 to 5 unused
// R08: Software reads and writes every flag bit
// R09: Location 01h holds no bits
// R10: Location 03h holds no bits
// R11: Fetch loader key word from 0FFDEh
// R12: Key 00000h keeps loader, blocks erasure
// R13: Key 0AA55h disables loader, others enable
// R14: Bracketed values on power-on, others every clear
// R15: Unimplemented bits read zero, ignore writes
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH

`define RCF_IDX_EN2      2'h1
`define RCF_IDX_FLAGS    2'h2
`define RCF_IDX_FLG2     2'h3

`define RCF_FLAG_W       5
`define RCF_BIT_WDT      0
`define RCF_BIT_OSC      1
`define RCF_BIT_POR      2
`define RCF_BIT_RST      3
`define RCF_BIT_NMI      4

`define RCF_POR_VAL      5'h06
`define RCF_CLR_MASK     5'h12
`define RCF_CLR_VAL      5'h02

`define RCF_KEY_ADDR     16'hFFDE
`define RCF_KEY_NO_ERASE 16'h0000
`define RCF_KEY_LDR_OFF  16'hAA55

`endif

// ---- rcf_pkg.sv ----
// Types of the reset-cause and fault flag block.
// Assumes rcf_params.svh supplies the numbers.
package rcf_pkg;

  typedef enum logic [0:0] {KEY_FETCH, KEY_DONE} rcf_key_state_t;

  typedef logic [1:0] rcf_idx_t;

endpackage

// ---- rcf_wb_slave.sv ----
// Classic Wishbone slave front end for the flag block.
// Assumes byte registers at word indices 1 to 3, one clock.
`timescale 1ns/1ps
`include "rcf_params.svh"
module rcf_wb_slave
  import rcf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Register side
  output rcf_idx_t         idx_o,
  output logic             wr_o,
  output logic      [7:0]  wdat_o,
  input  wire logic [7:0]  rdata_i
);

  logic req;
  logic hit;

  assign idx_o  = adr_i[3:2];
  assign wdat_o = dat_i[7:0];
  assign req    = cyc_i && stb_i && !ack_o && !err_o;
  assign hit    = (adr_i[1:0] == 2'h0) && (idx_o != 2'h0);
  assign wr_o   = req && hit && we_i && sel_i[0];

  // One-cycle answer, dropped in the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      ack_o <= req && hit;
      err_o <= req && !hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (req && hit && !we_i)
      dat_o <= {24'h0, rdata_i};
    else
      dat_o <= 32'h0;
  end

endmodule

// ---- rcf_key_decode.sv ----
// Fetches and decodes the loader security key word.
// Assumes a memory port that answers a held read with one ack pulse.
`timescale 1ns/1ps
`include "rcf_params.svh"
module rcf_key_decode
  import rcf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        restart_i,
  // Key fetch port
  output logic             key_rd_o,
  output logic      [15:0] key_addr_o,
  input  wire logic [15:0] key_data_i,
  input  wire logic        key_ack_i,
  // Decoded key
  output logic             key_valid_o,
  output logic             loader_en_o,
  output logic             erase_en_o
);

  rcf_key_state_t state;

  assign key_rd_o   = (state == KEY_FETCH);
  assign key_addr_o = `RCF_KEY_ADDR; // [R11]

  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i)
      state <= KEY_FETCH;
    else if (key_ack_i)
      state <= KEY_DONE;
  end

  // Loader held off until the key is known
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i)
    begin
      key_valid_o <= 1'b0;
      loader_en_o <= 1'b0;
      erase_en_o  <= 1'b1;
    end
    else if (key_rd_o && key_ack_i)
    begin
      key_valid_o <= 1'b1;
      loader_en_o <= (key_data_i != `RCF_KEY_LDR_OFF); // [R13]
      erase_en_o  <= (key_data_i != `RCF_KEY_NO_ERASE); // [R12]
    end
  end

endmodule

// ---- rcf_flags.sv ----
// Reset-cause and fault flag registers with loader key decode.
// Assumes one-cycle event pulses from the reset logic, synchronous
// to clk_i, and a classic Wishbone master on the register side.
`timescale 1ns/1ps
`include "rcf_params.svh"
module rcf_flags
  import rcf_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Reset and fault events
  input  wire logic        por_i,
  input  wire logic        pwr_clr_i,
  input  wire logic        wdt_overflow_i,
  input  wire logic        wdt_mode_i,
  input  wire logic        key_violation_i,
  input  wire logic        osc_fault_i,
  input  wire logic        pin_event_i,
  input  wire logic        pin_reset_mode_i,
  // Flag state
  output logic      [7:0]  flags_o,
  // Key fetch port
  output logic             key_rd_o,
  output logic      [15:0] key_addr_o,
  input  wire logic [15:0] key_data_i,
  input  wire logic        key_ack_i,
  // Loader control
  output logic             key_valid_o,
  output logic             loader_en_o,
  output logic             erase_en_o
);

  localparam int FW = `RCF_FLAG_W;
  localparam logic [FW-1:0] POR_VAL  = `RCF_POR_VAL;
  localparam logic [FW-1:0] CLR_MASK = `RCF_CLR_MASK;
  localparam logic [FW-1:0] CLR_VAL  = `RCF_CLR_VAL;

  rcf_idx_t      idx;
  logic          bus_wr;
  logic [7:0]    bus_wdat;
  logic [7:0]    rdata;
  logic          sw_wr;
  logic          pin_reset;
  logic          pin_nmi;
  logic          wdt_set;
  logic [FW-1:0] flags;
  logic [FW-1:0] hw_set;
  logic [FW-1:0] hw_clr;

  rcf_wb_slave u_bus
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .adr_i   (adr_i),
    .sel_i   (sel_i),
    .dat_i   (dat_i),
    .dat_o   (dat_o),
    .ack_o   (ack_o),
    .err_o   (err_o),
    .idx_o   (idx),
    .wr_o    (bus_wr),
    .wdat_o  (bus_wdat),
    .rdata_i (rdata)
  );

  rcf_key_decode u_key
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .restart_i   (por_i || pwr_clr_i),
    .key_rd_o    (key_rd_o),
    .key_addr_o  (key_addr_o),
    .key_data_i  (key_data_i),
    .key_ack_i   (key_ack_i),
    .key_valid_o (key_valid_o),
    .loader_en_o (loader_en_o),
    .erase_en_o  (erase_en_o)
  );

  // Pin role follows its configured mode
  assign pin_reset = pin_event_i && pin_reset_mode_i;
  assign pin_nmi   = pin_event_i && !pin_reset_mode_i;
  assign wdt_set   = (wdt_overflow_i && wdt_mode_i) || key_violation_i; // [R01]

  always_comb
  begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[`RCF_BIT_WDT] = wdt_set; // [R01]
    hw_set[`RCF_BIT_OSC] = osc_fault_i; // [R03]
    hw_set[`RCF_BIT_RST] = pin_reset; // [R04]
    hw_set[`RCF_BIT_NMI] = pin_nmi; // [R06]
    hw_clr[`RCF_BIT_WDT] = pin_reset; // [R02]
  end

  // Writes to the empty locations and upper bits go nowhere
  assign sw_wr = bus_wr && (idx == `RCF_IDX_FLAGS); // [R08] [R15]

  // Power-on load, then power-up clear, then events over software
  for (genvar b = 0; b < FW; b++)
  begin : g_flag
    always_ff @(posedge clk_i)
    begin
      if (rst_i || por_i)
        flags[b] <= POR_VAL[b]; // [R02] [R04] [R05] [R14]
      else if (pwr_clr_i && CLR_MASK[b])
        flags[b] <= CLR_VAL[b]; // [R03] [R06] [R14]
      else if (hw_set[b])
        flags[b] <= 1'b1;
      else if (hw_clr[b])
        flags[b] <= 1'b0; // [R02]
      else if (sw_wr)
        flags[b] <= bus_wdat[b]; // [R08]
    end
  end

  // Read view: only the flag byte has bits
  always_comb
  begin
    unique case (idx)
      `RCF_IDX_FLAGS: rdata = {3'h0, flags}; // [R07]
      `RCF_IDX_EN2:   rdata = 8'h00; // [R09]
      `RCF_IDX_FLG2:  rdata = 8'h00; // [R10]
      default:        rdata = 8'h00; // [R15]
    endcase
  end

  assign flags_o = {3'h0, flags}; // [R07]

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = !por_i && !pwr_clr_i && !wdt_set && !osc_fault_i && !pin_event_i;
  logic bus_take;
  assign bus_take = cyc_i && stb_i && !ack_o && !err_o;

  chk_wdt_set: assert property ( // [R01]
    wdt_set && !por_i |=> flags[`RCF_BIT_WDT])
    else $error("watchdog flag not set by overflow or key violation");

  chk_wdt_clear: assert property ( // [R02]
    (por_i || (pin_reset && !wdt_set)) |=> !flags[`RCF_BIT_WDT])
    else $error("watchdog flag not cleared by power-up or pin reset");

  chk_osc_set: assert property ( // [R03]
    (osc_fault_i || pwr_clr_i) && !por_i |=> flags[`RCF_BIT_OSC])
    else $error("oscillator fault flag not set");

  chk_ext_reset: assert property ( // [R04]
    pin_reset && !wdt_set && !por_i |=> flags[`RCF_BIT_RST] && !flags[`RCF_BIT_WDT])
    else $error("external reset flag wrong after pin reset");

  chk_power_on: assert property ( // [R05]
    por_i |=> flags[`RCF_BIT_POR] && !flags[`RCF_BIT_RST] && flags[`RCF_BIT_OSC])
    else $error("power-on flags wrong after supply power-up");

  chk_nmi_flag: assert property ( // [R06]
    pin_nmi && !por_i && !pwr_clr_i |=> flags[`RCF_BIT_NMI] ##1 (flags[`RCF_BIT_NMI] || $past(por_i || pwr_clr_i || sw_wr)))
    else $error("pin NMI flag not set or lost");

  chk_nmi_clear: assert property ( // [R06]
    pwr_clr_i |=> !flags[`RCF_BIT_NMI])
    else $error("pin NMI flag survives power-up clear");

  chk_read_zero: assert property ( // [R07]
    ack_o |-> dat_o[31:5] == 27'h0)
    else $error("unimplemented bits read nonzero");

  chk_empty_loc: assert property ( // [R09] [R10]
    cyc_i && stb_i && !we_i && !ack_o && !err_o && idx != `RCF_IDX_FLAGS |=> dat_o == 32'h0)
    else $error("empty location reads nonzero");

  chk_sw_write: assert property ( // [R08]
    sw_wr && quiet |=> flags == $past(bus_wdat[4:0]))
    else $error("software write to flags not stored");

  chk_clear_keeps: assert property ( // [R14]
    pwr_clr_i && !por_i && !pin_reset && !sw_wr |=> $stable(flags[`RCF_BIT_POR]) && $stable(flags[`RCF_BIT_RST]))
    else $error("power-on bits disturbed by power-up clear");

  chk_key_off: assert property ( // [R13]
    key_rd_o && key_ack_i && key_data_i == `RCF_KEY_LDR_OFF && !por_i && !pwr_clr_i
      |=> key_valid_o && !loader_en_o)
    else $error("loader not disabled by key");

  chk_key_zero: assert property ( // [R12]
    key_rd_o && key_ack_i && key_data_i == `RCF_KEY_NO_ERASE && !por_i && !pwr_clr_i
      |=> key_valid_o && loader_en_o && !erase_en_o)
    else $error("zero key did not block erasure");

  chk_key_addr: assert property ( // [R11]
    key_rd_o |-> key_addr_o == `RCF_KEY_ADDR ##1 (key_rd_o || key_valid_o))
    else $error("key fetch address wrong or fetch dropped");

  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("bus answer held longer than one cycle");

  chk_bus_answer: assert property (
    bus_take && adr_i[1:0] == 2'h0 && idx != 2'h0 |=> ack_o && !err_o)
    else $error("mapped access not acknowledged in one cycle");

  chk_bus_refuse: assert property (
    bus_take && (adr_i[1:0] != 2'h0 || idx == 2'h0) |=> err_o && !ack_o)
    else $error("unmapped access not refused");

  chk_err_pulse: assert property (
    err_o |=> !err_o)
    else $error("bus error held longer than one cycle");

  chk_idle_data: assert property (
    !ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside an answer");

  chk_read_flags: assert property ( // [R07] [R08]
    bus_take && !we_i && idx == `RCF_IDX_FLAGS && adr_i[1:0] == 2'h0 |=> dat_o == {27'h0, $past(flags)})
    else $error("flag read returned wrong value");

  chk_empty_write: assert property ( // [R09] [R10] [R15]
    bus_take && we_i && idx != `RCF_IDX_FLAGS && quiet |=> $stable(flags))
    else $error("write to empty location changed flags");

  chk_lane_ignore: assert property ( // [R08]
    bus_take && we_i && !sel_i[0] && quiet |=> $stable(flags))
    else $error("write without low lane changed flags");

  chk_bad_write: assert property (
    bus_take && we_i && adr_i[1:0] != 2'h0 && quiet |=> $stable(flags))
    else $error("refused write changed flags");

  chk_por_hold: assert property ( // [R05] [R14]
    !por_i && !sw_wr |=> $stable(flags[`RCF_BIT_POR]))
    else $error("power-on flag moved without power-up or write");

  chk_ext_hold: assert property ( // [R04]
    flags[`RCF_BIT_RST] && !por_i && !sw_wr |=> flags[`RCF_BIT_RST])
    else $error("external reset flag lost");

  chk_ext_source: assert property ( // [R04]
    !flags[`RCF_BIT_RST] && !pin_reset && !sw_wr |=> !flags[`RCF_BIT_RST])
    else $error("external reset flag set without pin reset");

  chk_osc_hold: assert property ( // [R03]
    flags[`RCF_BIT_OSC] && !sw_wr |=> flags[`RCF_BIT_OSC])
    else $error("oscillator fault flag lost");

  chk_nmi_hold: assert property ( // [R06]
    flags[`RCF_BIT_NMI] && !por_i && !pwr_clr_i && !sw_wr |=> flags[`RCF_BIT_NMI])
    else $error("pin NMI flag lost");

  chk_nmi_source: assert property ( // [R06]
    !flags[`RCF_BIT_NMI] && !pin_nmi && !sw_wr |=> !flags[`RCF_BIT_NMI])
    else $error("pin NMI flag set without NMI event");

  chk_wdt_hold: assert property ( // [R01]
    flags[`RCF_BIT_WDT] && !por_i && !pin_reset && !sw_wr |=> flags[`RCF_BIT_WDT])
    else $error("watchdog flag lost");

  chk_wdt_source: assert property ( // [R01] [R02]
    !flags[`RCF_BIT_WDT] && !wdt_set && !sw_wr |=> !flags[`RCF_BIT_WDT])
    else $error("watchdog flag set without its event");

  chk_key_restart: assert property ( // [R11]
    (por_i || pwr_clr_i) |=> key_rd_o && !key_valid_o)
    else $error("key fetch not restarted");

  chk_key_other: assert property ( // [R13]
    key_rd_o && key_ack_i && key_data_i != `RCF_KEY_LDR_OFF && key_data_i != `RCF_KEY_NO_ERASE
      && !por_i && !pwr_clr_i |=> key_valid_o && loader_en_o && erase_en_o)
    else $error("ordinary key did not enable loader");

  chk_key_hold: assert property ( // [R11]
    key_valid_o && !por_i && !pwr_clr_i |=> key_valid_o && $stable(loader_en_o) && $stable(erase_en_o))
    else $error("decoded key changed without restart");

  chk_key_safe: assert property (
    !key_valid_o |-> !loader_en_o && erase_en_o)
    else $error("loader controls not safe before key");

  chk_key_once: assert property ( // [R11]
    !key_rd_o && !por_i && !pwr_clr_i |=> !key_rd_o)
    else $error("second key fetch without restart");

  cov_pin_reset: cover property (pin_reset ##1 flags[`RCF_BIT_RST]);
  cov_sw_clear: cover property (sw_wr && bus_wdat == 8'h00 ##1 flags == 5'h00);
  cov_key_off: cover property (key_valid_o && !loader_en_o);
  cov_nmi_read: cover property (flags[`RCF_BIT_NMI] ##1 ack_o && dat_o[4]);
  cov_key_zero: cover property (key_valid_o && loader_en_o && !erase_en_o);

endmodule

// ---- tb.sv ----
// Self-checking bench for the reset-cause flag block.
// Assumes rcf_flags answers each Wishbone request in one cycle.
`timescale 1ns/1ps
module tb
  import rcf_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        por_i = 1'b0;
  logic        pwr_clr_i = 1'b0;
  logic        wdt_overflow_i = 1'b0;
  logic        wdt_mode_i = 1'b0;
  logic        key_violation_i = 1'b0;
  logic        osc_fault_i = 1'b0;
  logic        pin_event_i = 1'b0;
  logic        pin_reset_mode_i = 1'b0;
  logic [15:0] key_data_i = 16'h0;
  logic        key_ack_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic [7:0]  flags_o;
  logic        key_rd_o;
  logic [15:0] key_addr_o;
  logic        key_valid_o;
  logic        loader_en_o;
  logic        erase_en_o;
  logic [33:0] exp_q[$];
  logic [33:0] cur;
  logic [31:0] r;
  int          errors = 0;
  int          tests_run = 0;
  int          seed = 32'hd38194a5;

  rcf_flags u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .por_i(por_i),
    .pwr_clr_i(pwr_clr_i),
    .wdt_overflow_i(wdt_overflow_i), .wdt_mode_i(wdt_mode_i), .key_violation_i(key_violation_i),
    .osc_fault_i(osc_fault_i), .pin_event_i(pin_event_i), .pin_reset_mode_i(pin_reset_mode_i),
    .flags_o(flags_o), .key_rd_o(key_rd_o), .key_addr_o(key_addr_o), .key_data_i(key_data_i),
    .key_ack_i(key_ack_i), .key_valid_o(key_valid_o), .loader_en_o(loader_en_o), .erase_en_o(erase_en_o));

  always #5 clk_i = ~clk_i;

  task close_out();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // One classic cycle; the answer is noted for the monitor
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s, input logic [32:0] e);
    int n;
    exp_q.push_back({w, e});
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
    if (n >= 20)
    begin
      errors++;
      close_out();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    dat_i <= ~dat_i;
    @(posedge clk_i);
  endtask

  // Event pulse order: por, clear, overflow, key violation, osc fault, pin
  task ev(input logic [5:0] v);
    @(posedge clk_i);
    {por_i, pwr_clr_i, wdt_overflow_i, key_violation_i, osc_fault_i, pin_event_i} <= v;
    @(posedge clk_i);
    {por_i, pwr_clr_i, wdt_overflow_i, key_violation_i, osc_fault_i, pin_event_i} <= 6'h00;
    @(negedge clk_i);
  endtask

  task key(input logic [15:0] k);
    ev(6'h20);
    check(33'({key_rd_o, key_valid_o, key_addr_o}), 33'({1'b1, 1'b0, 16'hFFDE}));
    @(posedge clk_i);
    key_ack_i  <= 1'b1;
    key_data_i <= k;
    @(posedge clk_i);
    key_ack_i  <= 1'b0;
    key_data_i <= ~k;
    @(negedge clk_i);
    check(33'({key_rd_o, key_valid_o, loader_en_o, erase_en_o}),
          33'({1'b0, 1'b1, k != 16'hAA55, k != 16'h0000}));
  endtask

  // Monitor: every answer is matched with the oldest note
  always @(negedge clk_i)
  begin
    if (!rst_i && (ack_o === 1'b1 || err_o === 1'b1))
    begin
      if (exp_q.size() == 0)
        check(33'h1FFFFFFFF, 33'h0);
      else
      begin
        cur = exp_q.pop_front();
        check({err_o, cur[33] ? 32'h0 : dat_o}, {cur[32], cur[33] ? 32'h0 : cur[31:0]});
      end
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check(33'(flags_o), 33'h06);
    wb(1'b0, 4'h8, 8'h00, 4'h1, 33'h06);
    wb(1'b1, 4'h4, 8'hFF, 4'hF, 33'h0);
    wb(1'b0, 4'h4, 8'h00, 4'hF, 33'h0);
    wb(1'b1, 4'hC, 8'hFF, 4'hF, 33'h0);
    wb(1'b0, 4'hC, 8'h00, 4'hF, 33'h0);
    wb(1'b1, 4'h8, 8'hFF, 4'h1, 33'h0);
    wb(1'b0, 4'h8, 8'h00, 4'h1, 33'h1F);
    wb(1'b1, 4'h8, 8'h00, 4'h0, 33'h0);
    wb(1'b0, 4'h8, 8'h00, 4'h1, 33'h1F);
    r = $random(seed);
    wb(1'b1, 4'h8, r[7:0], 4'h1, 33'h0);
    wb(1'b0, 4'h8, 8'h00, 4'h1, 33'(r[4:0]));
    wb(1'b0, 4'h0, 8'h00, 4'h1, 33'h100000000);
    wb(1'b1, 4'h9, 8'h00, 4'h1, 33'h100000000);
    wb(1'b1, 4'h8, 8'h00, 4'h1, 33'h0);
    ev(6'h08);
    check(33'(flags_o), 33'h00);
    @(posedge clk_i);
    wdt_mode_i <= 1'b1;
    ev(6'h08);
    check(33'(flags_o), 33'h01);
    wb(1'b1, 4'h8, 8'h00, 4'h1, 33'h0);
    ev(6'h04);
    check(33'(flags_o), 33'h01);
    ev(6'h02);
    check(33'(flags_o), 33'h03);
    @(posedge clk_i);
    pin_reset_mode_i <= 1'b1;
    ev(6'h01);
    check(33'(flags_o), 33'h0A);
    @(posedge clk_i);
    pin_reset_mode_i <= 1'b0;
    ev(6'h01);
    check(33'(flags_o), 33'h1A);
    wb(1'b1, 4'h8, 8'h18, 4'h1, 33'h0);
    ev(6'h10);
    check(33'(flags_o), 33'h0A);
    ev(6'h20);
    check(33'(flags_o), 33'h06);
    key(16'h0000);
    key(16'hAA55);
    r = $random(seed);
    key(r[15:0]);
    close_out();
  end
endmodule
